// ### rtl/mtpb_payload_builder.sv
// Purpose: Builds a media thread's start-up payload writes.
// Assumes: Coefficients arrive in block order, only for coded blocks.
// Notes: APB slave with zero wait states; one job at a time.
//
// Overview of operation
// - Picture coding type in header bits 19:18.
// - Picture structure code in header bits 17:16.
// - Header bits 15:0 stay zero.
// - Coefficients only for coded blocks, from the register after the header.
// - Block order Y0..Y3, Cb, Cr; skip uncoded.
// - Each block fills four consecutive registers.
// - With control bits 11 and 12 both set, push constants from R1, data follows them.
// - With control bit 11 set, snapshot flag goes to R0.7 bit 31.
// - Intra macroblock ignores coded block pattern.
`timescale 1ns/1ps
module mtpb_payload_builder
    import mtpb_pkg::*;
#(
    parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Coefficient stream from the video front end
    input wire logic coef_valid,
    input wire logic [COEF_W-1:0] coef_data,
    output logic coef_ready,
    // Snapshot condition from the dispatcher
    input wire logic snapshot_evt,
    // General register file write port
    output logic grf_valid,
    input wire logic grf_ready,
    output logic [REG_IDX_W-1:0] grf_reg,
    output logic [DW_IDX_W-1:0] grf_dw,
    output logic [DWORD_W-1:0] grf_data,
    // Status
    output logic busy
);

    // ******************************************
    // Coefficient path
    // ******************************************
    mtpb_stream_if #(.W(COEF_W)) fin_if ();
    mtpb_stream_if #(.W(COEF_W)) fout_if ();
    mtpb_stream_if #(.W(DWORD_W)) pk_if ();

    assign fin_if.valid = coef_valid;
    assign fin_if.data = coef_data;
    assign coef_ready = fin_if.ready;

    mtpb_fifo #(.W(COEF_W), .DEPTH(FIFO_DEPTH_P)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_s(fin_if.snk),
        .out_s(fout_if.src)
    );

    mtpb_coef_packer #(.IN_W(COEF_W), .OUT_W(DWORD_W)) u_pack (
        .clk(clk),
        .rst(rst),
        .in_s(fout_if.snk),
        .out_s(pk_if.src)
    );

    // ******************************************
    // Register port
    // ******************************************
    mtpb_state_t st_q;
    logic [31:0] ctrl_q;
    logic [31:0] job_q;
    logic [31:0] rd;
    logic [31:0] stat_word;
    logic [31:0] stat_clr;
    logic [7:0] wcnt_q;
    logic snap_q;
    logic snap_cap_q;
    logic err_q;
    logic acc;
    logic wr_en;
    logic hit;
    logic start_req;
    logic codes_ok;
    logic start;
    logic ov_q;

    assign acc = psel && penable;
    assign wr_en = acc && pwrite;
    assign pready = 1'b1;
    assign pslverr = acc && !hit;
    assign prdata = (acc && !pwrite) ? rd : '0;
    assign stat_clr = (wr_en && paddr == OFS_STAT) ? pwdata : '0;
    assign start_req = wr_en && paddr == OFS_CMD && pwdata[CMD_START_BIT];
    assign codes_ok = ctrl_q[CTRL_CLASS_LSB +: 2] != CODE_RESERVED &&
                      ctrl_q[CTRL_LAYOUT_LSB +: 2] != CODE_RESERVED;
    assign start = start_req && st_q == ST_IDLE && !ov_q && codes_ok;
    assign busy = (st_q != ST_IDLE) || ov_q;

    always_comb begin
        stat_word = '0;
        stat_word[STAT_BUSY_BIT] = busy;
        stat_word[STAT_SNAP_BIT] = snap_q;
        stat_word[STAT_ERR_BIT] = err_q;
        stat_word[STAT_CNT_LSB +: 8] = wcnt_q;
    end

    always_comb begin
        hit = 1'b1;
        rd = '0;
        case (paddr)
            OFS_CTRL: rd = ctrl_q;
            OFS_CMD: rd = '0;
            OFS_STAT: rd = stat_word;
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
        end else if (wr_en && paddr == OFS_CTRL) begin
            ctrl_q <= pwdata & CTRL_WMASK;
        end
    end

    // A reserved code is refused at start so no header carries it.
    always_ff @(posedge clk) begin
        if (rst) begin
            err_q <= 1'b0;
        end else if (start_req && st_q == ST_IDLE && !ov_q && !codes_ok) begin
            err_q <= 1'b1;
        end else if (stat_clr[STAT_ERR_BIT]) begin
            err_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            snap_q <= 1'b0;
        end else if (snapshot_evt) begin
            snap_q <= 1'b1;
        end else if (stat_clr[STAT_SNAP_BIT]) begin
            snap_q <= 1'b0;
        end
    end

    // Settings are latched so software may prepare the next job early.
    always_ff @(posedge clk) begin
        if (rst) begin
            job_q <= CTRL_RST;
            snap_cap_q <= 1'b0;
        end else if (start) begin
            job_q <= ctrl_q;
            snap_cap_q <= snap_q;
        end
    end

    // ******************************************
    // Payload sequencing
    // ******************************************
    logic [1:0] j_class;
    logic [1:0] j_layout;
    logic [4:0] j_pcnt;
    logic [5:0] coded;
    logic [7:0] mb_base;
    logic [7:0] hdr_reg;
    logic [7:0] coef_base;
    logic [7:0] coef_reg;
    logic [2:0] blk_q;
    logic [2:0] slot_q;
    logic [4:0] dcnt_q;
    logic cur_coded;
    logic last_blk;
    logic blk_done;
    logic issue;
    logic take;
    logic fire;
    logic [7:0] n_reg;
    logic [2:0] n_dw;
    logic [31:0] n_data;

    assign j_class = job_q[CTRL_CLASS_LSB +: 2];
    assign j_layout = job_q[CTRL_LAYOUT_LSB +: 2];
    assign j_pcnt = job_q[CTRL_PCNT_LSB +: 5];
    assign coded = job_q[CTRL_INTRA_BIT] ? ALL_BLOCKS
                                         : job_q[CTRL_CBP_LSB +: 6];
    assign mb_base = (job_q[CTRL_BSD_BIT] && job_q[CTRL_PUSH_BIT]) ?
                     8'(BASE_REG + {3'h0, j_pcnt}) : BASE_REG;
    assign hdr_reg = 8'(mb_base + 8'h01);
    assign coef_base = 8'(mb_base + 8'h02);
    assign coef_reg = 8'(coef_base + {3'h0, slot_q, 2'b00} +
                         {6'h0, dcnt_q[4:3]});
    assign cur_coded = coded[blk_q];
    assign last_blk = (blk_q == 3'(NUM_BLOCKS - 1));
    assign take = !ov_q || grf_ready;
    assign fire = issue && take;
    assign blk_done = (st_q == ST_COEF) && (!cur_coded ||
                      (fire && dcnt_q == 5'(DW_PER_BLOCK - 1)));
    assign pk_if.ready = (st_q == ST_COEF) && cur_coded && take;

    always_comb begin
        issue = 1'b0;
        n_reg = '0;
        n_dw = '0;
        n_data = '0;
        case (st_q)
            ST_ROOT: begin
                issue = 1'b1;
                n_reg = ROOT_REG;
                n_dw = ROOT_SNAP_DW;
                n_data[SNAP_FLAG_BIT] = snap_cap_q;
            end
            ST_HDR: begin
                issue = 1'b1;
                n_reg = hdr_reg;
                n_dw = HDR_DW;
                n_data[HDR_CLASS_LSB +: 2] = j_class;
                n_data[HDR_LAYOUT_LSB +: 2] = j_layout;
            end
            ST_COEF: begin
                issue = cur_coded && pk_if.valid;
                n_reg = coef_reg;
                n_dw = dcnt_q[2:0];
                n_data = pk_if.data;
            end
            default: issue = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (start) begin
                        st_q <= ctrl_q[CTRL_BSD_BIT] ? ST_ROOT : ST_HDR;
                    end
                end
                ST_ROOT: if (fire) st_q <= ST_HDR;
                ST_HDR: if (fire) st_q <= ST_COEF;
                ST_COEF: if (blk_done && last_blk) st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst || start) begin
            blk_q <= '0;
            slot_q <= '0;
            dcnt_q <= '0;
        end else if (st_q == ST_COEF) begin
            if (fire) begin
                dcnt_q <= 5'(dcnt_q + 5'h01);
            end
            if (blk_done) begin
                blk_q <= 3'(blk_q + 3'h1);
                if (cur_coded) begin
                    slot_q <= 3'(slot_q + 3'h1);
                end
            end
        end
    end

    // ******************************************
    // Output stage
    // ******************************************
    logic o_hdr_q;
    logic o_root_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            ov_q <= 1'b0;
            grf_reg <= '0;
            grf_dw <= '0;
            grf_data <= '0;
            o_hdr_q <= 1'b0;
            o_root_q <= 1'b0;
        end else if (take) begin
            ov_q <= issue;
            if (fire) begin
                grf_reg <= n_reg;
                grf_dw <= n_dw;
                grf_data <= n_data;
                o_hdr_q <= (st_q == ST_HDR);
                o_root_q <= (st_q == ST_ROOT);
            end
        end
    end

    assign grf_valid = ov_q;

    always_ff @(posedge clk) begin
        if (rst || start) begin
            wcnt_q <= '0;
        end else if (ov_q && grf_ready) begin
            wcnt_q <= 8'(wcnt_q + 8'h01);
        end
    end

    // ******************************************
    // Checks
    // ******************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_bsd_start;
        start && ctrl_q[CTRL_BSD_BIT] && snap_q;
    endsequence

    sequence s_blk_end;
        fire && st_q == ST_COEF && dcnt_q == 5'h1f;
    endsequence

    a_hdr_class: assert property (
        (ov_q && o_hdr_q) |-> (grf_data[19:18] == j_class &&
                               j_class != CODE_RESERVED))
        else $error("Header coding type wrong.");
    a_hdr_layout: assert property (
        (ov_q && o_hdr_q) |-> (grf_data[17:16] == j_layout &&
                               j_layout != CODE_RESERVED))
        else $error("Header structure code wrong.");
    a_hdr_reserved_zero: assert property (
        (ov_q && o_hdr_q) |-> (grf_data[15:0] == 16'h0000))
        else $error("Header reserved bits not zero.");
    a_coef_range: assert property (
        (ov_q && !o_hdr_q && !o_root_q) |-> (grf_reg >= coef_base &&
         grf_reg < coef_base + 4 * $countones(coded)))
        else $error("Coefficient write outside its range.");
    a_blk_order: assert property (
        (fire && st_q == ST_COEF && dcnt_q == 5'h00) |->
        (slot_q == $countones(coded & ((6'h01 << blk_q) - 6'h01))))
        else $error("Coded block out of order.");
    a_blk_four_regs: assert property (
        s_blk_end |-> (n_reg == coef_base + 4 * slot_q + 3 && n_dw == 3'h7)
        ##1 (slot_q == $past(slot_q) + 1))
        else $error("Block does not fill four registers.");
    a_push_offset: assert property (
        (ov_q && o_hdr_q) |-> (grf_reg ==
         ((job_q[CTRL_BSD_BIT] && job_q[CTRL_PUSH_BIT]) ? 2 + j_pcnt : 2)))
        else $error("Header not placed after push constants.");
    a_snap_root: assert property (
        s_bsd_start |=> (st_q == ST_ROOT && snap_cap_q) ##1
        (!ov_q || (o_root_q && grf_reg == 8'h00 && grf_data[31])))
        else $error("Snapshot flag missing from root dword.");
    a_snap_sticky: assert property (
        snapshot_evt |=> snap_q)
        else $error("Snapshot event lost.");
    a_intra_all: assert property (
        (st_q == ST_COEF && job_q[CTRL_INTRA_BIT]) |-> cur_coded)
        else $error("Intra macroblock skipped a block.");
endmodule

// ### rtl/mtpb_pkg.sv
// Purpose: Shared constants for the media thread payload builder.
// Assumes: 32-bit APB register words, 256-bit register-file entries.
// Notes: Offsets are byte addresses on the APB port.
package mtpb_pkg;

    // ******************************************
    // Widths and counts
    // ******************************************
    localparam int COEF_W = 16;
    localparam int DWORD_W = 32;
    localparam int FIFO_DEPTH = 16;
    localparam int REG_IDX_W = 8;
    localparam int DW_IDX_W = 3;
    localparam int NUM_BLOCKS = 6;
    localparam int DW_PER_BLOCK = 32;
    localparam int REGS_PER_BLOCK = 4;

    // ******************************************
    // Register offsets and fields
    // ******************************************
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_CMD = 12'h004;
    localparam logic [11:0] OFS_STAT = 12'h008;
    localparam int CTRL_CLASS_LSB = 0;
    localparam int CTRL_LAYOUT_LSB = 2;
    localparam int CTRL_INTRA_BIT = 4;
    localparam int CTRL_CBP_LSB = 5;
    localparam int CTRL_BSD_BIT = 11;
    localparam int CTRL_PUSH_BIT = 12;
    localparam int CTRL_PCNT_LSB = 16;
    localparam logic [31:0] CTRL_WMASK = 32'h001f_1fff;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int CMD_START_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_SNAP_BIT = 1;
    localparam int STAT_ERR_BIT = 2;
    localparam int STAT_CNT_LSB = 8;

    // ******************************************
    // Payload layout
    // ******************************************
    localparam int HDR_CLASS_LSB = 18;
    localparam int HDR_LAYOUT_LSB = 16;
    localparam int SNAP_FLAG_BIT = 31;
    localparam logic [7:0] ROOT_REG = 8'h00;
    localparam logic [2:0] ROOT_SNAP_DW = 3'h7;
    localparam logic [7:0] BASE_REG = 8'h01;
    localparam logic [2:0] HDR_DW = 3'h0;
    localparam logic [5:0] ALL_BLOCKS = 6'h3f;

    localparam logic [1:0] CODE_RESERVED = 2'h0;
    localparam logic [1:0] INTRA_PICTURE_CODE = 2'h1;
    localparam logic [1:0] PREDICTIVE_PICTURE_CODE = 2'h2;
    localparam logic [1:0] BIDIRECTIONAL_PICTURE_CODE = 2'h3;
    localparam logic [1:0] TOP_FIELD_CODE = 2'h1;
    localparam logic [1:0] BOTTOM_FIELD_CODE = 2'h2;
    localparam logic [1:0] FULL_FRAME_CODE = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ROOT,
        ST_HDR,
        ST_COEF
    } mtpb_state_t;

endpackage

// ### rtl/mtpb_stream_if.sv
// Purpose: Valid/ready stream between the builder's own modules.
// Assumes: Single clock domain.
// Notes: The source holds data stable while valid waits on ready.
`timescale 1ns/1ps
interface mtpb_stream_if #(
    parameter int W = 16
) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ### rtl/mtpb_fifo.sv
// Purpose: Coefficient FIFO in front of the packer.
// Assumes: DEPTH is a power of two of at least two.
// Notes: Ready on the fill side falls only when every entry is used.
`timescale 1ns/1ps
module mtpb_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Streams
    mtpb_stream_if.snk in_s,
    mtpb_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("FIFO depth must be a power of two of at least two.");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_s.ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_s.valid = (cnt_q != '0);
    assign out_s.data = mem[rp_q];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_s.data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    a_fifo_full_stall: assert property (@(posedge clk) disable iff (rst)
        (cnt_q == (AW+1)'(DEPTH) && !pop) |=>
        (cnt_q == (AW+1)'(DEPTH) && !in_s.ready))
        else $error("FIFO accepted data while full.");
endmodule

// ### rtl/mtpb_coef_packer.sv
// Purpose: Packs pairs of coefficient words into register dwords.
// Assumes: A block always brings an even count of coefficients.
// Notes: One output register; a stalled output stalls the input.
`timescale 1ns/1ps
module mtpb_coef_packer
    import mtpb_pkg::*;
#(
    parameter int IN_W = COEF_W,
    parameter int OUT_W = DWORD_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Streams
    mtpb_stream_if.snk in_s,
    mtpb_stream_if.src out_s
);
    if (2 * IN_W != OUT_W) begin : g_chk
        $error("Output width must be twice the input width.");
    end

    logic half_q;
    logic [IN_W-1:0] lo_q;
    logic ov_q;
    logic [OUT_W-1:0] od_q;
    logic acc;

    assign in_s.ready = !ov_q || out_s.ready;
    assign acc = in_s.valid && in_s.ready;
    assign out_s.valid = ov_q;
    assign out_s.data = od_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            half_q <= 1'b0;
            lo_q <= '0;
        end else if (acc) begin
            half_q <= !half_q;
            if (!half_q) begin
                lo_q <= in_s.data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ov_q <= 1'b0;
            od_q <= '0;
        end else if (acc && half_q) begin
            ov_q <= 1'b1;
            od_q <= {in_s.data, lo_q};
        end else if (out_s.ready) begin
            ov_q <= 1'b0;
        end
    end

    a_pack_order: assert property (@(posedge clk) disable iff (rst)
        (acc && half_q) |=> (ov_q && od_q == {$past(in_s.data), $past(lo_q)}))
        else $error("Coefficient pair packed in the wrong order.");
endmodule

// ### dv/mtpb_grf_sink.sv
// Purpose: Register-file consumer model for the payload builder.
// Assumes: One write is taken per edge with valid and ready high.
// Notes: Ready stalls at random when stall_en is high.
`timescale 1ns/1ps
module mtpb_grf_sink
    import mtpb_pkg::*;
#(
    parameter logic [31:0] SEED = 32'he6484aeb
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control from the bench
    input wire logic stall_en,
    // Register file write port
    input wire logic grf_valid,
    input wire logic [REG_IDX_W-1:0] grf_reg,
    input wire logic [DW_IDX_W-1:0] grf_dw,
    input wire logic [DWORD_W-1:0] grf_data,
    output logic grf_ready
);
    // Taken writes, oldest first, as {reg, dw, data}.
    logic [42:0] got[$];
    integer seed = SEED;

    always @(posedge clk) begin
        if (rst) begin
            grf_ready <= 1'b0;
        end else begin
            grf_ready <= !stall_en || ($random(seed) % 3 != 0);
        end
        if (!rst && grf_valid && grf_ready) begin
            got.push_back({grf_reg, grf_dw, grf_data});
        end
    end
endmodule

// ### dv/mtpb_payload_builder_test.sv
// Purpose: Self-checking bench for the payload builder.
// Assumes: APB master waits for pready; FIFO depth 16.
// Notes: A queue model predicts every register-file write.
`timescale 1ns/1ps
module mtpb_payload_builder_test
    import mtpb_pkg::*;
;
    logic clk = 0;
    logic rst = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic coef_valid = 0;
    logic snapshot_evt = 0;
    logic stall_en = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [15:0] coef_data = 0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic coef_ready;
    logic grf_valid;
    logic grf_ready;
    logic busy;
    logic [7:0] grf_reg;
    logic [2:0] grf_dw;
    logic [31:0] grf_data;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    integer seed = 32'he6484aeb;
    logic snap = 0;
    logic rerr;
    logic [31:0] rdat;
    logic [31:0] r;
    logic [42:0] exp_q[$];
    logic [15:0] cq[$];

    always #5 clk = ~clk;

    mtpb_payload_builder mtpb_payload_builder_i (.clk(clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .coef_valid(coef_valid),
        .coef_data(coef_data), .coef_ready(coef_ready),
        .snapshot_evt(snapshot_evt), .grf_valid(grf_valid),
        .grf_ready(grf_ready), .grf_reg(grf_reg), .grf_dw(grf_dw),
        .grf_data(grf_data), .busy(busy));

    mtpb_grf_sink mtpb_grf_sink_i (.clk(clk), .rst(rst),
        .stall_en(stall_en), .grf_valid(grf_valid), .grf_reg(grf_reg),
        .grf_dw(grf_dw), .grf_data(grf_data), .grf_ready(grf_ready));

    // A hang ends the run as a failure.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            close_out();
        end
    end

    task close_out();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task check(input string nm, input logic [63:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // The answer is taken at the same rising edge that sees pready.
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task feed();
        while (cq.size() > 0) begin
            coef_valid <= 1'b1;
            coef_data <= cq[0];
            do begin
                @(posedge clk);
            end while (coef_ready !== 1'b1);
            void'(cq.pop_front());
        end
        coef_valid <= 1'b0;
    endtask

    task run_job(input logic [1:0] cls, lay, input logic intra,
                 input logic [5:0] cbp, input logic bsd, push,
                 input logic [4:0] pcnt, input logic pre);
        logic [15:0] c0, c1;
        logic [42:0] g, e;
        logic [5:0] blk;
        int h, k, n;
        h = (bsd && push) ? 2 + pcnt : 2;
        blk = intra ? ALL_BLOCKS : cbp;
        k = 0;
        if (bsd) begin
            exp_q.push_back({ROOT_REG, ROOT_SNAP_DW, snap, 31'h0});
        end
        exp_q.push_back({h[7:0], HDR_DW, 12'h0, cls, lay, 16'h0});
        for (int b = 0; b < NUM_BLOCKS; b++) begin
            if (blk[b]) begin
                for (int d = 0; d < DW_PER_BLOCK; d++) begin
                    c0 = $random(seed);
                    c1 = $random(seed);
                    cq.push_back(c0);
                    cq.push_back(c1);
                    n = h + 1 + 4 * k + d / 8;
                    exp_q.push_back({n[7:0], d[2:0], c1, c0});
                end
                k++;
            end
        end
        apb(1'b1, OFS_CTRL, {11'h0, pcnt, 3'h0, push, bsd, cbp, intra,
            lay, cls});
        fork
            feed();
            begin
                if (pre) begin
                    repeat (24) @(posedge clk);
                    @(negedge clk);
                    check("coef_ready full", coef_ready, 0);
                    @(posedge clk);
                end
                apb(1'b1, OFS_CMD, 32'h1);
                do @(negedge clk); while (busy === 1'b1);
                @(posedge clk);
            end
        join
        apb(1'b0, OFS_STAT, 32'h0);
        n = exp_q.size();
        check("stat", rdat[15:0], {n[7:0], 6'h0, snap, 1'b0});
        check("writes", mtpb_grf_sink_i.got.size(), n);
        while (n > 0 && mtpb_grf_sink_i.got.size() > 0) begin
            g = mtpb_grf_sink_i.got.pop_front();
            e = exp_q.pop_front();
            check("grf", g, e);
        end
        exp_q.delete();
        mtpb_grf_sink_i.got.delete();
        $display("job %0d %0d %h done", cls, lay, blk);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, OFS_CTRL, 32'h0);
        check("ctrl reset", rdat, CTRL_RST);
        apb(1'b0, OFS_STAT, 32'h0);
        check("stat reset", rdat, 0);
        apb(1'b1, OFS_CTRL, 32'hffff_ffff);
        apb(1'b0, OFS_CTRL, 32'h0);
        check("ctrl mask", rdat, CTRL_WMASK);
        apb(1'b0, OFS_CMD, 32'h0);
        check("cmd read", rdat, 0);
        apb(1'b0, 12'h00c, 32'h0);
        check("unmapped", {rerr, rdat}, {1'b1, 32'h0});
        $display("registers done");
        // Reserved codes must start nothing.
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, OFS_CTRL, i ? 32'h1 : 32'hc);
            apb(1'b1, OFS_CMD, 32'h1);
            repeat (4) @(posedge clk);
            apb(1'b0, OFS_STAT, 32'h0);
            check("err", rdat[2:0], 3'h4);
            check("none", mtpb_grf_sink_i.got.size(), 0);
            apb(1'b1, OFS_STAT, 32'h4);
            apb(1'b0, OFS_STAT, 32'h0);
            check("err clear", rdat[2], 0);
        end
        $display("reserved codes done");
        for (int i = 1; i < 4; i++) begin
            for (int j = 1; j < 4; j++) begin
                r = $random(seed);
                stall_en <= r[15];
                run_job(i[1:0], j[1:0], r[0] & r[1], r[7:2], r[8], r[9],
                        r[14:10], 1'b0);
            end
        end
        stall_en <= 1'b1;
        run_job(2'h1, 2'h3, 1'b0, 6'h0, 1'b0, 1'b0, 5'h0, 1'b0);
        run_job(2'h3, 2'h2, 1'b1, 6'h0, 1'b1, 1'b1, 5'h1f, 1'b0);
        snapshot_evt <= 1'b1;
        @(posedge clk);
        snapshot_evt <= 1'b0;
        snap = 1'b1;
        run_job(2'h2, 2'h1, 1'b0, 6'h21, 1'b1, 1'b0, 5'h3, 1'b1);
        apb(1'b1, OFS_STAT, 32'h2);
        snap = 1'b0;
        apb(1'b0, OFS_STAT, 32'h0);
        check("snap clear", rdat[1], 0);
        close_out();
    end
endmodule
